// ### sim/tb.sv
// Self-checking bench for the timer software event block.
// Assumes the block's APB slave answers with one wait state.
`timescale 1ns/1ps
`include "timer_event_map.svh"
module tb;
  import timer_event_pkg::*;

  // Design inputs and outputs
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  addr_t paddr = '0;
  word_t pwdata = '0;
  word_t prdata;
  logic pready, pslverr;
  logic break_in = 1'b0;
  logic trigger_in = 1'b0;
  logic update_strobe, channel_one_strobe, channel_two_strobe;
  logic control_update_strobe, trigger_strobe, break_strobe;
  logic channel_one_dma_req, channel_two_dma_req, irq;
  int mismatches = 0;
  int comparisons = 0;
  int cycles = 0;

  timer_event_gen dut_u (
    .ref_clk(ref_clk), .rst_n(rst_n),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .break_in(break_in), .trigger_in(trigger_in),
    .update_strobe(update_strobe), .channel_one_strobe(channel_one_strobe),
    .channel_two_strobe(channel_two_strobe),
    .control_update_strobe(control_update_strobe),
    .trigger_strobe(trigger_strobe), .break_strobe(break_strobe),
    .channel_one_dma_req(channel_one_dma_req),
    .channel_two_dma_req(channel_two_dma_req), .irq(irq)
  );

  // 50 MHz clock
  always #10 ref_clk = ~ref_clk;

  // Hang guard
  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      mismatches++;
      wrap_up();
    end
  end

  task automatic wrap_up();
    $display("mismatches %0d comparisons %0d", mismatches, comparisons);
    if (mismatches == 0 && comparisons > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic check(input word_t seen, input word_t exp);
    comparisons++;
    if (seen !== exp) begin
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      mismatches++;
    end
  endtask

  // One APB transfer, held until pready is sampled high
  task automatic apb(input logic wr, input addr_t a, input word_t d,
                     output word_t r, output logic err);
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    @(posedge ref_clk);
    while (pready !== 1'b1) @(posedge ref_clk);
    r = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input addr_t a, input word_t d);
    word_t r;
    logic e;
    apb(1'b1, a, d, r, e);
  endtask

  task automatic rd(input addr_t a, input word_t exp);
    word_t r;
    logic e;
    apb(1'b0, a, 32'h0, r, e);
    check(r, exp);
  endtask

  // Strobes packed in the event register layout
  function automatic word_t strobes();
    word_t s;
    s = '0;
    s[`BIT_UPDATE] = update_strobe;
    s[`BIT_CH1] = channel_one_strobe;
    s[`BIT_CH2] = channel_two_strobe;
    s[`BIT_CONTROL] = control_update_strobe;
    s[`BIT_TRIGGER] = trigger_strobe;
    s[`BIT_BREAK] = break_strobe;
    return s;
  endfunction

  // Event write, strobes in the next cycle, DMA pulse one cycle later
  task automatic ev(input word_t d, input word_t exp, input logic [1:0] dma);
    word_t dma_seen;
    wr(`OFF_EVENT, d);
    #1;
    check(strobes(), exp);
    @(posedge ref_clk);
    #1;
    check(strobes(), 32'h0);
    dma_seen = {30'h0, channel_two_dma_req, channel_one_dma_req};
    check(dma_seen, {30'h0, dma});
  endtask

  task automatic t_reset();
    rd(`OFF_EVENT, 32'h0);
    rd(`OFF_STATUS, 32'h0);
    rd(`OFF_AUTO_RELOAD, 32'h0000FFFF);
  endtask

  // Counter reload on forced update in up, down and center modes
  task automatic t_update();
    wr(`OFF_PRESCALER, 32'h0000FFFF);
    wr(`OFF_AUTO_RELOAD, 32'h00001234);
    wr(`OFF_CONTROL, 32'h0);
    wr(`OFF_STATUS, 32'h0000FFFF);
    ev(32'h1, 32'h1, 2'b00);
    rd(`OFF_COUNTER, 32'h0);
    rd(`OFF_STATUS, 32'h1);
    wr(`OFF_CONTROL, 32'h1);
    ev(32'h1, 32'h1, 2'b00);
    rd(`OFF_COUNTER, 32'h00001234);
    wr(`OFF_CONTROL, 32'h2);
    ev(32'h1, 32'h1, 2'b00);
    rd(`OFF_COUNTER, 32'h0);
    wr(`OFF_CONTROL, 32'h1);
    ev(32'h1, 32'h1, 2'b00);
    rd(`OFF_COUNTER, 32'h00001234);
    rd(`OFF_PRESCALER, 32'h0000FFFF);
    wr(`OFF_STATUS, 32'h0000FFFF);
  endtask

  // Output and input channel events, interrupt and overcapture
  task automatic t_channels();
    wr(`OFF_DMA_ENABLE, 32'h6);
    wr(`OFF_IRQ_MASK, 32'h2);
    wr(`OFF_CHANNEL_MODE, 32'h0);
    ev(32'h2, 32'h2, 2'b01);
    rd(`OFF_STATUS, 32'h2);
    check({31'h0, irq}, 32'h1);
    wr(`OFF_IRQ_MASK, 32'h0);
    #1;
    check({31'h0, irq}, 32'h0);
    wr(`OFF_STATUS, 32'h0000FFFF);
    wr(`OFF_CHANNEL_MODE, 32'h3);
    ev(32'h6, 32'h6, 2'b11);
    rd(`OFF_STATUS, 32'h6);
    ev(32'h6, 32'h6, 2'b11);
    rd(`OFF_STATUS, 32'h606);
    rd(`OFF_CH1_VALUE, 32'h00001234);
    rd(`OFF_CH2_VALUE, 32'h00001234);
    wr(`OFF_STATUS, 32'h0000FFFF);
    rd(`OFF_STATUS, 32'h0);
  endtask

  // Control update only with a complementary channel
  task automatic t_control();
    wr(`OFF_CHANNEL_MODE, 32'h0);
    ev(32'h20, 32'h0, 2'b00);
    rd(`OFF_STATUS, 32'h0);
    wr(`OFF_CHANNEL_MODE, 32'h4);
    ev(32'h20, 32'h20, 2'b00);
    rd(`OFF_STATUS, 32'h20);
    rd(`OFF_STATUS, 32'h20);
    wr(`OFF_STATUS, 32'h0000FFFF);
  endtask

  // Trigger and break together, then ignored bits
  task automatic t_trig_break();
    ev(32'hC0, 32'hC0, 2'b00);
    rd(`OFF_STATUS, 32'hC0);
    wr(`OFF_STATUS, 32'h0000FFFF);
    rd(`OFF_STATUS, 32'h0);
    ev(32'h0000FF18, 32'h0, 2'b00);
    ev(32'h0, 32'h0, 2'b00);
    rd(`OFF_EVENT, 32'h0);
    rd(`OFF_STATUS, 32'h0);
  endtask

  // Break flag holds while the pin is active; trigger pin edge
  task automatic t_pins();
    break_in <= 1'b1;
    repeat (6) @(posedge ref_clk);
    wr(`OFF_STATUS, 32'h80);
    rd(`OFF_STATUS, 32'h80);
    break_in <= 1'b0;
    repeat (6) @(posedge ref_clk);
    wr(`OFF_STATUS, 32'h80);
    rd(`OFF_STATUS, 32'h0);
    trigger_in <= 1'b1;
    repeat (6) @(posedge ref_clk);
    rd(`OFF_STATUS, 32'h40);
    trigger_in <= 1'b0;
    wr(`OFF_STATUS, 32'h0000FFFF);
  endtask

  // Unmapped offset answers with an error
  task automatic t_unmapped();
    word_t r;
    logic e;
    apb(1'b1, 8'h40, 32'h0000FFFF, r, e);
    check({31'h0, e}, 32'h1);
    apb(1'b0, 8'h40, 32'h0, r, e);
    check(r, 32'h0);
    check({31'h0, e}, 32'h1);
  endtask

  // Main sequence
  initial begin
    repeat (3) @(posedge ref_clk);
    rst_n <= 1'b1;
    t_reset();
    t_update();
    t_channels();
    t_control();
    t_trig_break();
    t_pins();
    t_unmapped();
    wrap_up();
  end
endmodule

// ### src/capture_channel.sv
// One capture/compare channel: flag, overcapture flag, stored value.
// Assumes single-cycle event strobes from the timer on the same clock.
`timescale 1ns/1ps
`include "timer_event_map.svh"
module capture_channel (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // Event and mode
  input wire logic event_strobe,
  input wire logic is_input,
  input wire logic dma_enable,
  input wire timer_event_pkg::half_t counter,
  // Software access
  input wire logic clear_flag,
  input wire logic clear_over,
  input wire logic write_value,
  input wire timer_event_pkg::half_t value_in,
  // Results
  output timer_event_pkg::half_t value,
  output logic flag,
  output logic over_flag,
  output logic dma_req
);
  import timer_event_pkg::*;

  half_t next_value;
  logic next_flag;
  logic next_over_flag;
  logic next_dma_req;

  // Capture, flag setting; a set beats a clear in the same cycle
  always_comb begin
    next_value = value;
    if (event_strobe && is_input) begin
      next_value = counter;
    end else if (write_value && !is_input) begin
      next_value = value_in;
    end
    next_flag = event_strobe || (flag && !clear_flag);
    next_over_flag = (event_strobe && is_input && flag)
      || (over_flag && !clear_over);
    next_dma_req = event_strobe && dma_enable;
  end

  // Channel registers
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      value <= `RST_ZERO;
      flag <= 1'b0;
      over_flag <= 1'b0;
      dma_req <= 1'b0;
    end else begin
      value <= next_value;
      flag <= next_flag;
      over_flag <= next_over_flag;
      dma_req <= next_dma_req;
    end
  end
endmodule

// ### src/timer_event_gen.sv
// Timer software event generation with APB registers, a small counter,
// two capture channels and a level interrupt.
// Assumes an APB master on ref_clk and asynchronous break/trigger pins.
`timescale 1ns/1ps
`include "timer_event_map.svh"

module timer_event_gen (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire timer_event_pkg::addr_t paddr,
  input wire timer_event_pkg::word_t pwdata,
  output timer_event_pkg::word_t prdata,
  output logic pready,
  output logic pslverr,
  // External event pins
  input wire logic break_in,
  input wire logic trigger_in,
  // Event strobes to the rest of the timer
  output logic update_strobe,
  output logic channel_one_strobe,
  output logic channel_two_strobe,
  output logic control_update_strobe,
  output logic trigger_strobe,
  output logic break_strobe,
  // Requests
  output logic channel_one_dma_req,
  output logic channel_two_dma_req,
  output logic irq
);
  import timer_event_pkg::*;

  // Software registers
  logic [1:0] control;
  half_t irq_mask;
  logic [1:0] dma_enable;
  logic [3:0] channel_mode;
  half_t prescaler;
  half_t auto_reload_value;
  logic [1:0] next_control;
  half_t next_irq_mask;
  logic [1:0] next_dma_enable;
  logic [3:0] next_channel_mode;
  half_t next_prescaler;
  half_t next_auto_reload_value;

  // Bus state
  logic next_pready;
  logic next_pslverr;
  word_t next_prdata;
  logic bus_done;
  logic bus_wr;
  logic bus_rd;
  logic addr_hit;

  // Pin synchronisers
  logic [1:0] break_sync;
  logic [1:0] trigger_sync;
  logic trigger_seen;
  logic break_active;
  logic trigger_rise;

  // Event strobes and flags
  half_t event_write;
  logic next_update_strobe;
  logic next_channel_one_strobe;
  logic next_channel_two_strobe;
  logic next_control_update_strobe;
  logic next_trigger_strobe;
  logic next_break_strobe;
  logic update_flag;
  logic control_update_flag;
  logic trigger_flag;
  logic break_flag;
  logic next_update_flag;
  logic next_control_update_flag;
  logic next_trigger_flag;
  logic next_break_flag;
  half_t status_clear;

  // Counter
  half_t prescale_count;
  half_t counter;
  logic center_down;
  half_t next_prescale_count;
  half_t next_counter;
  logic next_center_down;
  logic natural_update;
  count_mode_t count_mode;

  // Channels
  half_t channel_one_capture_value;
  half_t channel_two_capture_value;
  logic channel_one_flag;
  logic channel_two_flag;
  logic channel_one_overcapture_flag;
  logic channel_two_overcapture_flag;
  half_t status;

  // Decodes the counting mode from the control bits
  function automatic count_mode_t mode_of(input logic [1:0] ctl);
    if (ctl[1]) begin
      return COUNT_CENTER;
    end else if (ctl[0]) begin
      return COUNT_DOWN;
    end
    return COUNT_UP;
  endfunction

  // Tells whether an offset is one of the mapped registers
  function automatic logic is_mapped(input addr_t a);
    case (a)
      `OFF_CONTROL, `OFF_IRQ_MASK, `OFF_DMA_ENABLE, `OFF_CHANNEL_MODE,
      `OFF_STATUS, `OFF_EVENT, `OFF_PRESCALER, `OFF_AUTO_RELOAD,
      `OFF_COUNTER, `OFF_CH1_VALUE, `OFF_CH2_VALUE: return 1'b1;
      default: return 1'b0;
    endcase
  endfunction

  // Bus qualifiers; the access completes on the edge with pready high
  assign bus_done = psel && penable && pready;
  assign bus_wr = bus_done && pwrite && !pslverr;
  assign bus_rd = bus_done && !pwrite && !pslverr;
  assign addr_hit = is_mapped(paddr);
  assign count_mode = mode_of(control);
  assign break_active = break_sync[1];
  assign trigger_rise = trigger_sync[1] && !trigger_seen;
  assign status = {5'h00, channel_two_overcapture_flag,
    channel_one_overcapture_flag, 1'b0, break_flag, trigger_flag,
    control_update_flag, 2'h0, channel_two_flag, channel_one_flag,
    update_flag};
  assign irq = |(status & irq_mask);

  // Software register writes and one wait state bus answer
  always_comb begin
    next_control = control;
    next_irq_mask = irq_mask;
    next_dma_enable = dma_enable;
    next_channel_mode = channel_mode;
    next_prescaler = prescaler;
    next_auto_reload_value = auto_reload_value;
    if (bus_wr) begin
      case (paddr)
        `OFF_CONTROL: next_control = pwdata[1:0];
        `OFF_IRQ_MASK: next_irq_mask = pwdata[15:0] & `STATUS_USED;
        `OFF_DMA_ENABLE: next_dma_enable = pwdata[2:1];
        `OFF_CHANNEL_MODE: next_channel_mode = pwdata[3:0];
        `OFF_PRESCALER: next_prescaler = pwdata[15:0];
        `OFF_AUTO_RELOAD: next_auto_reload_value = pwdata[15:0];
        default: next_control = control;
      endcase
    end
    next_pready = psel && penable && !pready;
    next_pslverr = psel && penable && !pready && !addr_hit;
    next_prdata = 32'h0000_0000;
    if (psel && penable && !pready) begin
      case (paddr)
        `OFF_CONTROL: next_prdata = {30'h0, control};
        `OFF_IRQ_MASK: next_prdata = {16'h0000, irq_mask};
        `OFF_DMA_ENABLE: next_prdata = {29'h0, dma_enable, 1'b0};
        `OFF_CHANNEL_MODE: next_prdata = {28'h0, channel_mode};
        `OFF_STATUS: next_prdata = {16'h0000, status};
        `OFF_PRESCALER: next_prdata = {16'h0000, prescaler};
        `OFF_AUTO_RELOAD: next_prdata = {16'h0000, auto_reload_value};
        `OFF_COUNTER: next_prdata = {16'h0000, counter};
        `OFF_CH1_VALUE: next_prdata = {16'h0000, channel_one_capture_value};
        `OFF_CH2_VALUE: next_prdata = {16'h0000, channel_two_capture_value};
        default: next_prdata = 32'h0000_0000;
      endcase
    end
  end

  // Registers of the bus side
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      control <= 2'h0;
      irq_mask <= `RST_ZERO;
      dma_enable <= 2'h0;
      channel_mode <= 4'h0;
      prescaler <= `RST_ZERO;
      auto_reload_value <= `RST_RELOAD;
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      control <= next_control;
      irq_mask <= next_irq_mask;
      dma_enable <= next_dma_enable;
      channel_mode <= next_channel_mode;
      prescaler <= next_prescaler;
      auto_reload_value <= next_auto_reload_value;
      pready <= next_pready;
      pslverr <= next_pslverr;
      prdata <= next_prdata;
    end
  end

  // Event bits written as one; zeros and reserved bits drop out
  always_comb begin
    event_write = `RST_ZERO;
    if (bus_wr && paddr == `OFF_EVENT) begin
      event_write = pwdata[15:0] & `EVENT_USED;
    end
    status_clear = `RST_ZERO;
    if (bus_wr && paddr == `OFF_STATUS) begin
      status_clear = pwdata[15:0];
    end
    // Each strobe lasts one cycle, so the bit clears itself
    next_update_strobe = event_write[`BIT_UPDATE];
    next_channel_one_strobe = event_write[`BIT_CH1];
    next_channel_two_strobe = event_write[`BIT_CH2];
    next_control_update_strobe = event_write[`BIT_CONTROL]
      && (channel_mode[`BIT_CH1_COMPL]
      || channel_mode[`BIT_CH2_COMPL]);
    next_trigger_strobe = event_write[`BIT_TRIGGER]
      || trigger_rise;
    next_break_strobe = event_write[`BIT_BREAK];
    // Sticky flags, set wins over a write-one clear
    next_update_flag = update_strobe || natural_update
      || (update_flag && !status_clear[`BIT_UPDATE]);
    next_control_update_flag = control_update_strobe
      || (control_update_flag && !status_clear[`BIT_CONTROL]);
    next_trigger_flag = trigger_strobe
      || (trigger_flag && !status_clear[`BIT_TRIGGER]);
    next_break_flag = break_strobe || break_active
      || (break_flag && !status_clear[`BIT_BREAK]);
  end

  // Event strobes, flags and pin synchronisers
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      update_strobe <= 1'b0;
      channel_one_strobe <= 1'b0;
      channel_two_strobe <= 1'b0;
      control_update_strobe <= 1'b0;
      trigger_strobe <= 1'b0;
      break_strobe <= 1'b0;
      update_flag <= 1'b0;
      control_update_flag <= 1'b0;
      trigger_flag <= 1'b0;
      break_flag <= 1'b0;
      break_sync <= 2'h0;
      trigger_sync <= 2'h0;
      trigger_seen <= 1'b0;
    end else begin
      update_strobe <= next_update_strobe;
      channel_one_strobe <= next_channel_one_strobe;
      channel_two_strobe <= next_channel_two_strobe;
      control_update_strobe <= next_control_update_strobe;
      trigger_strobe <= next_trigger_strobe;
      break_strobe <= next_break_strobe;
      update_flag <= next_update_flag;
      control_update_flag <= next_control_update_flag;
      trigger_flag <= next_trigger_flag;
      break_flag <= next_break_flag;
      break_sync <= {break_sync[0], break_in};
      trigger_sync <= {trigger_sync[0], trigger_in};
      trigger_seen <= trigger_sync[1];
    end
  end

  // Prescaler and counter; a forced update reinitialises both
  always_comb begin
    next_prescale_count = prescale_count + 16'h0001;
    next_counter = counter;
    next_center_down = center_down;
    natural_update = 1'b0;
    if (update_strobe) begin
      next_prescale_count = `RST_ZERO;
      next_center_down = 1'b0;
      next_counter = (count_mode == COUNT_DOWN) ? auto_reload_value
        : `RST_ZERO;
    end else if (prescale_count >= prescaler) begin
      next_prescale_count = `RST_ZERO;
      case (count_mode)
        COUNT_DOWN: begin
          natural_update = (counter == `RST_ZERO);
          next_counter = natural_update ? auto_reload_value
            : counter - 16'h0001;
        end
        COUNT_CENTER: begin
          if (!center_down && counter >= auto_reload_value) begin
            next_center_down = 1'b1;
            natural_update = 1'b1;
            next_counter = counter - 16'h0001;
          end else if (center_down && counter == `RST_ZERO) begin
            next_center_down = 1'b0;
            natural_update = 1'b1;
            next_counter = counter + 16'h0001;
          end else begin
            next_counter = center_down ? counter - 16'h0001
              : counter + 16'h0001;
          end
        end
        default: begin
          natural_update = (counter >= auto_reload_value);
          next_counter = natural_update ? `RST_ZERO : counter + 16'h0001;
        end
      endcase
    end
  end

  // Counter registers
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      prescale_count <= `RST_ZERO;
      counter <= `RST_ZERO;
      center_down <= 1'b0;
    end else begin
      prescale_count <= next_prescale_count;
      counter <= next_counter;
      center_down <= next_center_down;
    end
  end

  // Channel one; reading its value also clears its flag
  capture_channel channel_one (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .event_strobe(channel_one_strobe),
    .is_input(channel_mode[`BIT_CH1_INPUT]),
    .dma_enable(dma_enable[0]),
    .counter(counter),
    .clear_flag(status_clear[`BIT_CH1]
      || (bus_rd && paddr == `OFF_CH1_VALUE)),
    .clear_over(status_clear[`BIT_CH1_OVER]),
    .write_value(bus_wr && paddr == `OFF_CH1_VALUE),
    .value_in(pwdata[15:0]),
    .value(channel_one_capture_value),
    .flag(channel_one_flag),
    .over_flag(channel_one_overcapture_flag),
    .dma_req(channel_one_dma_req)
  );

  // Channel two, same behaviour
  capture_channel channel_two (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .event_strobe(channel_two_strobe),
    .is_input(channel_mode[`BIT_CH2_INPUT]),
    .dma_enable(dma_enable[1]),
    .counter(counter),
    .clear_flag(status_clear[`BIT_CH2]
      || (bus_rd && paddr == `OFF_CH2_VALUE)),
    .clear_over(status_clear[`BIT_CH2_OVER]),
    .write_value(bus_wr && paddr == `OFF_CH2_VALUE),
    .value_in(pwdata[15:0]),
    .value(channel_two_capture_value),
    .flag(channel_two_flag),
    .over_flag(channel_two_overcapture_flag),
    .dma_req(channel_two_dma_req)
  );

  // Checks
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  a_update_self_clear: assert property (
    bus_wr && paddr == `OFF_EVENT && pwdata[0]
    |=> update_strobe ##1 !update_strobe)
    else $error("update strobe not a single pulse");
  a_prescale_restart: assert property (
    update_strobe |=> prescale_count == `RST_ZERO && $stable(prescaler))
    else $error("prescaler count not cleared on update");
  a_update_load_value: assert property (
    update_strobe && count_mode == COUNT_DOWN
    |=> counter == $past(auto_reload_value))
    else $error("down counter did not load reload value");
  a_update_load_zero: assert property (
    update_strobe && count_mode != COUNT_DOWN |=> counter == `RST_ZERO)
    else $error("counter not cleared on update");
  a_channel_flag_set: assert property (
    channel_one_strobe |=> channel_one_flag
    && channel_one_dma_req == $past(dma_enable[0]))
    else $error("channel one event lost");
  a_channel_capture: assert property (
    channel_one_strobe && channel_mode[`BIT_CH1_INPUT]
    |=> channel_one_capture_value == $past(counter))
    else $error("channel one capture wrong");
  a_overcapture_set: assert property (
    channel_two_strobe && channel_mode[`BIT_CH2_INPUT] && channel_two_flag
    |=> channel_two_overcapture_flag)
    else $error("channel two overcapture missed");
  a_control_update_gate: assert property (
    control_update_strobe |-> channel_mode[3:2] != 2'h0
    ##1 control_update_flag)
    else $error("control update on plain channels");
  a_trigger_flag_set: assert property (
    bus_wr && paddr == `OFF_EVENT && pwdata[6]
    |=> trigger_strobe ##1 trigger_flag)
    else $error("trigger flag not set");
  a_break_flag_hold: assert property (
    break_active |=> break_flag)
    else $error("break flag cleared while break active");
  a_multi_event_same: assert property (
    bus_wr && paddr == `OFF_EVENT && pwdata[7:6] == 2'h3
    |=> break_strobe && trigger_strobe)
    else $error("simultaneous events split");
  a_event_reads_zero: assert property (
    bus_done && !pwrite && paddr == `OFF_EVENT |-> prdata == 32'h0)
    else $error("event register read not zero");
endmodule

// ### src/timer_event_map.svh
// Register offsets, field positions, reset values and timing counts
// of the timer event block. Assumes an 8-bit APB byte address.
`ifndef TIMER_EVENT_MAP_SVH
`define TIMER_EVENT_MAP_SVH

// Register byte offsets
`define OFF_CONTROL 8'h00
`define OFF_IRQ_MASK 8'h04
`define OFF_DMA_ENABLE 8'h08
`define OFF_CHANNEL_MODE 8'h0C
`define OFF_STATUS 8'h10
`define OFF_EVENT 8'h14
`define OFF_PRESCALER 8'h18
`define OFF_AUTO_RELOAD 8'h1C
`define OFF_COUNTER 8'h20
`define OFF_CH1_VALUE 8'h24
`define OFF_CH2_VALUE 8'h28

// Event and status bit positions (shared layout)
`define BIT_UPDATE 0
`define BIT_CH1 1
`define BIT_CH2 2
`define BIT_CONTROL 5
`define BIT_TRIGGER 6
`define BIT_BREAK 7
`define BIT_CH1_OVER 9
`define BIT_CH2_OVER 10

// Channel mode bit positions
`define BIT_CH1_INPUT 0
`define BIT_CH2_INPUT 1
`define BIT_CH1_COMPL 2
`define BIT_CH2_COMPL 3

// Implemented bits and reset values
`define EVENT_USED 16'h00E7
`define STATUS_USED 16'h06E7
`define RST_ZERO 16'h0000
`define RST_RELOAD 16'hFFFF

// Read-to-ready latency of the bus slave, in clock cycles
`define BUS_WAIT_CYCLES 1

`endif

// ### src/timer_event_pkg.sv
// Types shared by the timer event block and its channel unit.
// Assumes nothing of its surroundings.
package timer_event_pkg;
  typedef logic [15:0] half_t;
  typedef logic [31:0] word_t;
  typedef logic [7:0] addr_t;
  typedef enum {COUNT_UP, COUNT_DOWN, COUNT_CENTER} count_mode_t;
endpackage
